// >>> hw/tws_pkg.sv
// Shared constants and types for the two-wire byte sequencer.
// Assumes the unit top imports it whole; no other dependencies.
package tws_pkg;
  // Control, own-address and status register bit positions
  localparam int CTL_DONE = 7;
  localparam int CTL_ACKEN = 6;
  localparam int CTL_START = 5;
  localparam int CTL_STOP = 4;
  localparam int CTL_WCOL = 3;
  localparam int CTL_EN = 2;
  localparam int CTL_IE = 0;
  localparam int OWN_GCE = 0;
  localparam int CODE_LSB = 3;
  localparam logic STATUS_RSV = 1'h0;
  // Reset values, and the bit count of the ACK slot
  localparam logic [7:0] CTL_RST = 8'h00;
  localparam logic [7:0] DATA_RST = 8'hff;
  localparam logic [7:0] OWN_RST = 8'hfe;
  localparam logic [1:0] PRESC_RST = 2'h0;
  localparam logic [3:0] LAST_BIT = 4'h8;
  // Bus timing: one quarter of a bit cell, least time, rounded up
  localparam int SCL_QTR_NS = 2500;
  localparam int LINK_PERIOD_PS = 30000;
  localparam int TICK_W = 7;
  localparam logic [TICK_W-1:0] SCL_QTR_CYC = TICK_W'(
    (SCL_QTR_NS * 1000 + LINK_PERIOD_PS - 1) / LINK_PERIOD_PS);
  typedef enum logic [4:0] {
    ST_START = 5'h01, ST_ADDR_W_ACK = 5'h02, ST_ADDR_W_NACK = 5'h03,
    ST_TX_ACK = 5'h04, ST_TX_NACK = 5'h05, ST_ADDR_R_ACK = 5'h06,
    ST_ADDR_R_NACK = 5'h07, ST_RX_ACK = 5'h08, ST_RX_NACK = 5'h09,
    ST_OWN_ADDR = 5'h0a, ST_GEN_CALL = 5'h0b, ST_NO_BUS = 5'h0c,
    ST_IDLE = 5'h1f
  } tws_code_t;
  typedef enum logic [1:0] {
    CMD_BYTE = 2'h0, CMD_START = 2'h1, CMD_STOP = 2'h2
  } tws_cmd_t;
  typedef enum logic [3:0] {
    S_IDLE = 4'h0, S_START = 4'h1, S_HOLD = 4'h3, S_BYTE = 4'h2,
    S_STOP = 4'h6, S_SLV_BITS = 4'h7, S_SLV_ACK = 4'h5,
    S_SLV_HOLD = 4'h4
  } tws_state_t;
endpackage

// >>> hw/tws_sync3.sv
// Three-stage synchroniser; a bit changes once stages two and three agree.
// Assumes the destination clock and its async low reset.
`timescale 1ns/1ps
`default_nettype none
module tws_sync3 #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RST = '0
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [WIDTH-1:0] d,
  output var logic [WIDTH-1:0] q
);
  logic [WIDTH-1:0] s1;
  logic [WIDTH-1:0] s2;
  logic [WIDTH-1:0] s3;

  // First stage is read only by the second
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s1 <= RST;
      s2 <= RST;
      s3 <= RST;
    end else begin
      s1 <= d;
      s2 <= s1;
      s3 <= s2;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      q <= RST;
    end else begin
      q <= (s3 & ~(s2 ^ s3)) | (q & (s2 ^ s3));
    end
  end
endmodule
`default_nettype wire

// >>> hw/tws_two_wire_unit.sv
// Two-wire master byte sequencer with own-address and general call watch.
// Assumes software on clk and a separate link clock for the bus engine.
//
// What this block does
// R01: General call recognised only when its enable set
// R02: Job-done flag raised after every handled event except STOP completion and slave release
// R03: Interrupt only when flag, enable, global enable
// R04: Without interrupt enable software polls the flag
// R05: Status code valid whenever flag is set
// R06: Writing one clears flag; zero leaves it
// R07: No new bus operation while flag set
// R08: START begins right after flag cleared
// R09: START completion sets flag with START code
// R10: Data register sources address and data bytes
// R11: Byte completion code tells ACK from NACK
// R12: Data sent sets flag with data code
// R13: STOP completion never raises the flag
// R14: SCL held low while flag is set, except after the no-bus code
// R15: Software loads registers before clearing flag
// R16: Every action request writes flag bit one
// R17: After clear, carry out the written settings
// R18: Software checks status code after each step
// R19: Status code in bits 7..3, prescaler low
// R20: Data write with flag low sets collision
// R21: STOP request bit self-clears after STOP
// R22: Data register stable while flag set
// R23: Reset leaves block idle with flag clear
`timescale 1ns/1ps
`default_nettype none
module tws_two_wire_unit import tws_pkg::*; (
  input wire logic clk,
  input wire logic resetn,
  input wire logic linkClk,
  input wire logic ctrlWe,
  input wire logic [7:0] ctrlWdata,
  input wire logic dataWe,
  input wire logic [7:0] dataWdata,
  input wire logic ownAddrWe,
  input wire logic [7:0] ownAddrWdata,
  input wire logic prescWe,
  input wire logic [1:0] prescWdata,
  input wire logic coreGlobalIe,
  output var logic [7:0] wireControlReg,
  output var logic [7:0] busStateCodeReg,
  output var logic [7:0] shiftByteReg,
  output var logic [7:0] ownAddressReg,
  output var logic irq,
  input wire logic sclIn,
  output var logic sclOut,
  output var logic sclOen,
  input wire logic sdaIn,
  output var logic sdaOut,
  output var logic sdaOen
);
  ////////////////////////////////////////////////////////////////////////
  // Software side (clk)
  logic jobDone;
  logic doneTogS;
  logic doneSeen;
  logic doneEvt;
  logic busy;
  logic issue;
  logic cmdTog;
  tws_cmd_t cmdKind;
  logic [7:0] cmdByte;
  logic cmdAckEn;
  // Link side results; doneTog is synchronised every cycle, the rest read by clk only on doneEvt
  logic doneTog;
  tws_code_t doneCode;
  logic doneRaise;
  logic [7:0] doneByte;

  assign jobDone = wireControlReg[CTL_DONE];
  assign doneEvt = doneTogS ^ doneSeen;
  // A request starts only from a write that clears the flag
  assign issue = ctrlWe && ctrlWdata[CTL_DONE] && ctrlWdata[CTL_EN]
    && !busy; // see R07 see R16

  tws_sync3 #(.WIDTH(1), .RST(1'h0)) doneSync (
    .clk(clk),
    .rstn(resetn),
    .d(doneTog),
    .q(doneTogS)
  );

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      doneSeen <= 1'h0;
    end else begin
      doneSeen <= doneTogS;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      wireControlReg <= CTL_RST; // see R23
    end else begin
      if (ctrlWe) begin
        wireControlReg[CTL_ACKEN] <= ctrlWdata[CTL_ACKEN];
        wireControlReg[CTL_START] <= ctrlWdata[CTL_START];
        wireControlReg[CTL_STOP] <= ctrlWdata[CTL_STOP];
        wireControlReg[CTL_EN] <= ctrlWdata[CTL_EN];
        wireControlReg[CTL_IE] <= ctrlWdata[CTL_IE];
        if (ctrlWdata[CTL_DONE]) begin
          wireControlReg[CTL_DONE] <= 1'h0; // see R06
        end
      end
      if (dataWe) begin
        wireControlReg[CTL_WCOL] <= !jobDone; // see R20
      end
      // Completion set comes last so it wins over a same-cycle clear
      if (doneEvt && doneRaise) begin
        wireControlReg[CTL_DONE] <= 1'h1; // see R02
      end
      if (doneEvt && !doneRaise) begin
        wireControlReg[CTL_STOP] <= 1'h0; // see R13 see R21
      end
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      busy <= 1'h0;
    end else if (ctrlWe && !ctrlWdata[CTL_EN]) begin
      busy <= 1'h0;
    end else if (issue) begin
      busy <= 1'h1;
    end else if (doneEvt) begin
      busy <= 1'h0;
    end
  end

  // Command word is held still from the toggle until the next issue
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cmdTog <= 1'h0;
      cmdKind <= CMD_BYTE;
      cmdByte <= DATA_RST;
      cmdAckEn <= 1'h0;
    end else if (issue) begin
      cmdTog <= !cmdTog; // see R17
      cmdByte <= shiftByteReg; // see R10
      cmdAckEn <= ctrlWdata[CTL_ACKEN];
      if (ctrlWdata[CTL_STOP]) begin
        cmdKind <= CMD_STOP;
      end else if (ctrlWdata[CTL_START]) begin
        cmdKind <= CMD_START; // see R08
      end else begin
        cmdKind <= CMD_BYTE;
      end
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      shiftByteReg <= DATA_RST;
    end else if (doneEvt && doneRaise) begin
      shiftByteReg <= doneByte;
    end else if (dataWe && jobDone) begin
      shiftByteReg <= dataWdata; // see R22
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      busStateCodeReg <= {ST_IDLE, STATUS_RSV, PRESC_RST};
    end else begin
      if (doneEvt) begin
        busStateCodeReg[7:CODE_LSB] <= doneCode; // see R05 see R19
      end
      if (prescWe) begin
        busStateCodeReg[1:0] <= prescWdata;
      end
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ownAddressReg <= OWN_RST;
    end else if (ownAddrWe) begin
      ownAddressReg <= ownAddrWdata;
    end
  end

  // Polling stays possible: the flag is visible whatever the enables
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      irq <= 1'h0;
    end else begin
      irq <= jobDone && wireControlReg[CTL_IE] && coreGlobalIe; // see R03
    end
  end

  a_flag_raise: assert property (@(posedge clk) disable iff (!resetn)
    doneEvt && doneRaise |=> jobDone) // see R02
    else $error("flag not raised on completion");
  a_irq_raise: assert property (@(posedge clk) disable iff (!resetn)
    jobDone && wireControlReg[CTL_IE] && coreGlobalIe |=> irq) // see R03
    else $error("interrupt missing");
  a_irq_gated: assert property (@(posedge clk) disable iff (!resetn)
    !(wireControlReg[CTL_IE] && coreGlobalIe) |=> !irq) // see R03
    else $error("interrupt while disabled");
  a_clear_one: assert property (@(posedge clk) disable iff (!resetn)
    ctrlWe && ctrlWdata[CTL_DONE] && !doneEvt |=> !jobDone) // see R06
    else $error("flag not cleared by one");
  a_hold_zero: assert property (@(posedge clk) disable iff (!resetn)
    jobDone && ctrlWe && !ctrlWdata[CTL_DONE] |=> jobDone) // see R06
    else $error("flag lost on zero write");
  a_start_gate: assert property (@(posedge clk) disable iff (!resetn)
    $changed(cmdTog) |-> $past(ctrlWe && ctrlWdata[CTL_DONE])) // see R07
    else $error("operation begun without flag clear");
  a_code_load: assert property (@(posedge clk) disable iff (!resetn)
    $rose(jobDone) |-> busStateCodeReg[7:CODE_LSB] == $past(doneCode))
    else $error("status code not loaded"); // see R05
  a_byte_src: assert property (@(posedge clk) disable iff (!resetn)
    issue |=> cmdByte == $past(shiftByteReg)) // see R10
    else $error("byte not taken from data register");
  a_wcol_set: assert property (@(posedge clk) disable iff (!resetn)
    dataWe && !jobDone && !doneEvt |=> wireControlReg[CTL_WCOL]
    && $stable(shiftByteReg)) // see R20
    else $error("collision not flagged");
  a_data_keep: assert property (@(posedge clk) disable iff (!resetn)
    jobDone && $past(jobDone) && !$past(dataWe)
    |-> $stable(shiftByteReg)) // see R22
    else $error("data changed while flag set");
  a_stop_quiet: assert property (@(posedge clk) disable iff (!resetn)
    doneEvt && !doneRaise && !ctrlWe |=> !wireControlReg[CTL_STOP]
    && $stable(jobDone)) // see R13
    else $error("stop completion misreported");

  ////////////////////////////////////////////////////////////////////////
  // Link side (linkClk)
  logic lrst1;
  logic lrstn;
  logic [1:0] pinS;
  logic sclS;
  logic sdaS;
  logic sclPrev;
  logic sdaPrev;
  logic [8:0] cfgS;
  logic enS;
  logic cmdTogS;
  logic cmdSeen;
  logic cmdEvt;
  tws_state_t state;
  logic [1:0] qtr;
  logic [TICK_W-1:0] tick;
  logic qEnd;
  logic [3:0] bitCnt;
  logic [7:0] txByte;
  logic [7:0] rxByte;
  logic isAddr;
  logic rdMode;
  logic ackEn;
  logic ackSeen;
  logic gcHit;
  logic ownHit;

  assign sclS = pinS[1];
  assign sdaS = pinS[0];
  assign enS = cfgS[8];
  assign cmdEvt = cmdTogS ^ cmdSeen;
  assign qEnd = tick == SCL_QTR_CYC - 1'h1;
  assign gcHit = rxByte == 8'h00 && cfgS[OWN_GCE]; // see R01
  assign ownHit = rxByte[7:1] == cfgS[7:1] && !rxByte[0];

  // Reset asserts at once, releases on the link clock
  always_ff @(posedge linkClk or negedge resetn) begin
    if (!resetn) begin
      lrst1 <= 1'h0;
      lrstn <= 1'h0;
    end else begin
      lrst1 <= 1'h1;
      lrstn <= lrst1;
    end
  end

  tws_sync3 #(.WIDTH(2), .RST(2'h3)) pinSync (
    .clk(linkClk),
    .rstn(lrstn),
    .d({sclIn, sdaIn}),
    .q(pinS)
  );

  // Address and enable are quasi-static; software changes them idle
  tws_sync3 #(.WIDTH(9), .RST(9'h000)) cfgSync (
    .clk(linkClk),
    .rstn(lrstn),
    .d({wireControlReg[CTL_EN], ownAddressReg}),
    .q(cfgS)
  );

  tws_sync3 #(.WIDTH(1), .RST(1'h0)) cmdSync (
    .clk(linkClk),
    .rstn(lrstn),
    .d(cmdTog),
    .q(cmdTogS)
  );

  always_ff @(posedge linkClk or negedge lrstn) begin
    if (!lrstn) begin
      sclPrev <= 1'h1;
      sdaPrev <= 1'h1;
    end else begin
      sclPrev <= sclS;
      sdaPrev <= sdaS;
    end
  end

  // Quarter-bit timer; waits in the third quarter for a stretched SCL
  always_ff @(posedge linkClk or negedge lrstn) begin
    if (!lrstn) begin
      tick <= '0;
    end else if (!(state inside {S_START, S_BYTE, S_STOP}) || qEnd) begin
      tick <= '0;
    end else if (qtr == 2'h2 && !sclS) begin
      tick <= '0;
    end else begin
      tick <= tick + 1'h1;
    end
  end

  task automatic report(input tws_code_t code, input logic raise);
    doneCode <= code;
    doneRaise <= raise;
    doneByte <= rxByte;
    doneTog <= !doneTog;
  endtask

  always_ff @(posedge linkClk or negedge lrstn) begin
    if (!lrstn) begin
      state <= S_IDLE;
      qtr <= 2'h0;
      bitCnt <= 4'h0;
      txByte <= DATA_RST;
      rxByte <= DATA_RST;
      isAddr <= 1'h0;
      rdMode <= 1'h0;
      ackEn <= 1'h0;
      ackSeen <= 1'h0;
      cmdSeen <= 1'h0;
      sclOen <= 1'h1;
      sdaOen <= 1'h1;
      sclOut <= 1'h0;
      sdaOut <= 1'h0;
      doneTog <= 1'h0;
      doneCode <= ST_IDLE;
      doneRaise <= 1'h0;
      doneByte <= DATA_RST;
    end else if (!enS) begin
      // Switched off: drop any transfer and release both lines
      state <= S_IDLE;
      cmdSeen <= cmdTogS;
      sclOen <= 1'h1;
      sdaOen <= 1'h1;
    end else begin
      if (qEnd) begin
        qtr <= qtr + 1'h1;
      end
      case (state)
        S_IDLE: begin
          sclOen <= 1'h1;
          sdaOen <= 1'h1;
          if (cmdEvt) begin
            cmdSeen <= cmdTogS;
            if (cmdKind == CMD_START) begin
              state <= S_START; // see R08
              qtr <= 2'h0;
            end else if (cmdKind == CMD_STOP) begin
              report(ST_IDLE, 1'h0);
            end else begin
              report(ST_NO_BUS, 1'h1);
            end
          end else if (sclS && sdaPrev && !sdaS) begin
            state <= S_SLV_BITS;
            bitCnt <= 4'h0;
          end
        end
        S_START: begin
          if (qEnd && qtr == 2'h0) begin
            sclOen <= 1'h1;
          end
          if (qEnd && qtr == 2'h1) begin
            sdaOen <= 1'h0;
          end
          if (qEnd && qtr == 2'h3) begin
            sclOen <= 1'h0;
            isAddr <= 1'h1;
            rdMode <= 1'h0;
            state <= S_HOLD;
            report(ST_START, 1'h1); // see R09
          end
        end
        S_HOLD: begin
          sclOen <= 1'h0; // see R14
          if (cmdEvt) begin
            cmdSeen <= cmdTogS;
            qtr <= 2'h0;
            bitCnt <= 4'h0;
            ackEn <= cmdAckEn;
            if (cmdKind == CMD_START) begin
              sdaOen <= 1'h1;
              state <= S_START;
            end else if (cmdKind == CMD_STOP) begin
              sdaOen <= 1'h0;
              state <= S_STOP;
            end else begin
              txByte <= cmdByte;
              sdaOen <= rdMode && !isAddr ? 1'h1 : cmdByte[7];
              state <= S_BYTE;
            end
          end
        end
        S_BYTE: begin
          if (qEnd && qtr == 2'h1) begin
            sclOen <= 1'h1;
          end
          if (qEnd && qtr == 2'h2) begin
            if (bitCnt == LAST_BIT) begin
              ackSeen <= !sdaS;
            end else begin
              rxByte <= {rxByte[6:0], sdaS};
            end
          end
          if (qEnd && qtr == 2'h3) begin
            sclOen <= 1'h0;
            bitCnt <= bitCnt + 1'h1;
            if (bitCnt == LAST_BIT) begin
              sdaOen <= 1'h1;
              isAddr <= 1'h0;
              state <= S_HOLD;
              if (isAddr) begin
                rdMode <= txByte[0];
                if (txByte[0]) begin
                  report(ackSeen ? ST_ADDR_R_ACK : ST_ADDR_R_NACK,
                    1'h1); // see R11
                end else begin
                  report(ackSeen ? ST_ADDR_W_ACK : ST_ADDR_W_NACK,
                    1'h1); // see R11
                end
              end else if (rdMode) begin
                report(ackEn ? ST_RX_ACK : ST_RX_NACK, 1'h1);
              end else begin
                report(ackSeen ? ST_TX_ACK : ST_TX_NACK, 1'h1); // see R12
              end
            end else if (bitCnt == LAST_BIT - 1'h1) begin
              sdaOen <= rdMode && !isAddr ? !ackEn : 1'h1;
            end else begin
              sdaOen <= rdMode && !isAddr ? 1'h1 : txByte[6 - bitCnt];
            end
          end
        end
        S_STOP: begin
          if (qEnd && qtr == 2'h1) begin
            sclOen <= 1'h1;
          end
          if (qEnd && qtr == 2'h3) begin
            sdaOen <= 1'h1;
            state <= S_IDLE;
            report(ST_IDLE, 1'h0); // see R13 see R21
          end
        end
        S_SLV_BITS: begin
          if (!sclPrev && sclS) begin
            rxByte <= {rxByte[6:0], sdaS};
            bitCnt <= bitCnt + 1'h1;
          end
          if (sclPrev && !sclS && bitCnt == LAST_BIT) begin
            if (gcHit || ownHit) begin
              sdaOen <= 1'h0;
              state <= S_SLV_ACK;
            end else begin
              state <= S_IDLE;
            end
          end
        end
        S_SLV_ACK: begin
          if (sclPrev && !sclS) begin
            sdaOen <= 1'h1;
            sclOen <= 1'h0; // see R14
            state <= S_SLV_HOLD;
            report(gcHit ? ST_GEN_CALL : ST_OWN_ADDR, 1'h1); // see R01
          end
        end
        S_SLV_HOLD: begin
          sclOen <= 1'h0;
          if (cmdEvt) begin
            cmdSeen <= cmdTogS;
            sclOen <= 1'h1;
            state <= S_IDLE;
            report(ST_IDLE, 1'h0);
          end
        end
        default: begin
          state <= S_IDLE;
        end
      endcase
    end
  end

  a_scl_stretch: assert property (@(posedge linkClk) disable iff (!lrstn)
    state inside {S_HOLD, S_SLV_HOLD} |-> !sclOen) // see R14
    else $error("SCL released while waiting");
  a_gc_enable: assert property (@(posedge linkClk) disable iff (!lrstn)
    $changed(doneTog) && doneCode == ST_GEN_CALL |-> cfgS[OWN_GCE])
    else $error("general call taken while disabled"); // see R01
  a_start_begin: assert property (@(posedge linkClk) disable iff (!lrstn)
    state == S_IDLE && cmdEvt && enS && cmdKind == CMD_START
    |=> state == S_START ##1 sdaOen) // see R08
    else $error("START not begun");
endmodule
`default_nettype wire

// >>> testbench/tws_slave_model.sv
// Behavioural bus slave that takes writes and acknowledges its address.
// Assumes pulled-up open-drain lines; it sees only the resolved levels.
`timescale 1ns/1ps
`default_nettype none
module tws_slave_model #(
  parameter logic [6:0] ADDR = 7'h48
) (
  input wire logic scl,
  input wire logic sda,
  input wire logic stretchEn,
  output var logic sclOen,
  output var logic sdaOen,
  output var logic [7:0] lastByte
);
  logic [3:0] cnt;
  logic active;
  logic first;
  logic sel;
  logic [7:0] sh;
  initial begin
    sclOen = 1'b1;
    sdaOen = 1'b1;
    active = 1'b0;
    sel = 1'b0;
    lastByte = 8'h00;
  end
  ////////////////////////////////////////////////////////////////////////////
  always @(negedge sda) if (scl) begin
    active = 1'b1;
    first = 1'b1;
    cnt = 4'h0;
  end
  always @(posedge sda) if (scl) active = 1'b0;
  always @(posedge scl) if (active) begin
    if (cnt < 4'h8) begin
      sh = {sh[6:0], sda};
      cnt = cnt + 4'h1;
    end else cnt = 4'h0;
  end
  // Release on every fall but the ACK one so a stale low never lingers into data bits
  always @(negedge scl) begin
    if (active && cnt == 4'h8) begin
      lastByte = sh;
      if (first) sel = (sh[7:1] == ADDR) && !sh[0];
      first = 1'b0;
      sdaOen = ~sel;
    end else sdaOen = 1'b1;
  end
  // Slow answer: hold the clock low a while after each fall
  always @(negedge scl) if (stretchEn && active) begin
    sclOen = 1'b0;
    #4000 sclOen = 1'b1;
  end
endmodule
`default_nettype wire

// >>> testbench/tb_top.sv
// Self-checking bench for the two-wire sequencer with one bus slave.
// Assumes the sequencer package and pull-ups on both bus lines.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import tws_pkg::*;
  logic clk, resetn, linkClk, ctrlWe, dataWe, ownAddrWe, prescWe;
  logic [7:0] ctrlWdata, dataWdata, ownAddrWdata, old;
  logic [1:0] prescWdata;
  logic [7:0] wireControlReg, busStateCodeReg, shiftByteReg, ownAddressReg;
  logic coreGlobalIe, irq, sclOen, sdaOen, mSclOen, mSdaOen;
  logic tbScl, tbSda, stretch, ack;
  logic [7:0] lastByte;
  wire logic sclW;
  wire logic sdaW;
  int failures, tests_run;
  typedef struct packed {
    logic [7:0] d;
    logic [7:0] c;
    logic gie;
    logic st;
    logic [4:0] code;
  } tws_row_t;
  tws_row_t rows [7] = '{
    '{8'hff, 8'ha5, 1'b1, 1'b0, ST_START},
    '{8'h90, 8'h84, 1'b1, 1'b0, ST_ADDR_W_ACK},
    '{8'h5a, 8'h85, 1'b0, 1'b1, ST_TX_ACK},
    '{8'h00, 8'h94, 1'b0, 1'b0, ST_IDLE},
    '{8'hff, 8'ha4, 1'b0, 1'b0, ST_START},
    '{8'h44, 8'h84, 1'b0, 1'b0, ST_ADDR_W_NACK},
    '{8'h00, 8'h94, 1'b0, 1'b0, ST_IDLE}};
  assign sclW = sclOen & mSclOen & tbScl;
  assign sdaW = sdaOen & mSdaOen & tbSda;
  ////////////////////////////////////////////////////////////////////////////
  tws_two_wire_unit dut_u (.clk(clk), .resetn(resetn), .linkClk(linkClk),
    .ctrlWe(ctrlWe), .ctrlWdata(ctrlWdata), .dataWe(dataWe),
    .dataWdata(dataWdata), .ownAddrWe(ownAddrWe),
    .ownAddrWdata(ownAddrWdata), .prescWe(prescWe),
    .prescWdata(prescWdata), .coreGlobalIe(coreGlobalIe),
    .wireControlReg(wireControlReg), .busStateCodeReg(busStateCodeReg),
    .shiftByteReg(shiftByteReg), .ownAddressReg(ownAddressReg),
    .irq(irq), .sclIn(sclW), .sclOut(), .sclOen(sclOen), .sdaIn(sdaW),
    .sdaOut(), .sdaOen(sdaOen));
  tws_slave_model slave_u (.scl(sclW), .sda(sdaW), .stretchEn(stretch),
    .sclOen(mSclOen), .sdaOen(mSdaOen), .lastByte(lastByte));
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  initial begin
    linkClk = 1'b0;
    #7;
    forever #15 linkClk = ~linkClk;
  end
  task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
    tests_run++;
    if (s !== e) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic wr(input int k, input logic [7:0] d);
    @(negedge clk);
    ctrlWdata = d;
    dataWdata = d;
    ownAddrWdata = d;
    prescWdata = d[1:0];
    {ctrlWe, dataWe, ownAddrWe, prescWe} = {k == 0, k == 1, k == 2, k == 3};
    @(negedge clk);
    {ctrlWe, dataWe, ownAddrWe, prescWe} = 4'h0;
  endtask
  task automatic waitBit(input int b, input logic v);
    int n;
    n = 0;
    while (wireControlReg[b] !== v && n < 8000) begin
      @(negedge clk);
      n++;
    end
    chk("wait", wireControlReg[b], v);
  endtask
  task automatic rst();
    @(negedge clk);
    resetn = 1'b0;
    repeat (5) @(negedge clk);
    chk("rstCtl", wireControlReg, 8'h00);
    chk("rstCode", busStateCodeReg, {ST_IDLE, 3'h0});
    chk("rstData", shiftByteReg, 8'hff);
    chk("rstOwn", ownAddressReg, 8'hfe);
    chk("rstOut", {irq, sclOen, sdaOen}, 8'h03);
    resetn = 1'b1;
    repeat (10) @(negedge clk);
    wr(0, 8'h04);
    repeat (10) @(negedge clk);
    $display("reset test done");
  endtask
  // Test driver acting as another master; 10 us per bit
  task automatic busBit(input logic b, output logic s);
    tbSda = b;
    #2500 tbScl = 1'b1;
    #2500 s = sdaW;
    #2500 tbScl = 1'b0;
    #2500;
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial begin
    repeat (60000) @(posedge clk);
    failures++;
    $display("[FAIL] watchdog expected done seen timeout");
    print_verdict();
  end
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    {resetn, ctrlWe, dataWe, ownAddrWe, prescWe, coreGlobalIe} = 6'h00;
    {ctrlWdata, dataWdata, ownAddrWdata, prescWdata} = 26'h0;
    {tbScl, tbSda, stretch} = 3'b110;
    failures = 0;
    tests_run = 0;
    rst();
    foreach (rows[i]) begin
      coreGlobalIe = rows[i].gie;
      stretch = rows[i].st;
      if (wireControlReg[7] === 1'b1) wr(1, rows[i].d);
      wr(0, rows[i].c);
      if (rows[i].c[4]) begin
        waitBit(4, 1'b0);
        chk("stopFlag", wireControlReg[7], 1'b0);
        chk("idle", busStateCodeReg, {ST_IDLE, 3'h0});
      end else begin
        waitBit(7, 1'b1);
        repeat (3) @(negedge clk);
        chk("code", busStateCodeReg, {rows[i].code, 3'h0});
        chk("irq", irq, rows[i].c[0] & rows[i].gie);
        chk("sclHeld", sclOen, 1'b0);
        if (rows[i].code != ST_START) begin
          chk("data", shiftByteReg, rows[i].d);
          chk("wire", lastByte, rows[i].d);
        end
        repeat (40) @(negedge clk);
        chk("stillHeld", {wireControlReg[7], sclOen}, 8'h02);
      end
      $display("row %0d done", i);
    end
    old = shiftByteReg;
    wr(1, 8'h3c);
    chk("wcolSet", wireControlReg[3], 1'b1);
    chk("dataKeep", shiftByteReg, old);
    wr(0, 8'h84);
    waitBit(7, 1'b1);
    chk("noBus", busStateCodeReg, {ST_NO_BUS, 3'h0});
    wr(1, 8'h3c);
    chk("wcolClr", wireControlReg[3], 1'b0);
    chk("dataLoad", shiftByteReg, 8'h3c);
    wr(0, 8'h04);
    chk("flagKeep", wireControlReg[7], 1'b1);
    wr(0, 8'h94);
    chk("flagClr", wireControlReg[7], 1'b0);
    // The stop bit only drops once the engine has answered across domains
    waitBit(4, 1'b0);
    chk("ctlHigh", wireControlReg[4 +: 4], 4'h0);
    wr(3, 8'h03);
    chk("presc", busStateCodeReg[2:0], 3'h3);
    $display("hand tests done");
    for (int g = 0; g < 2; g++) begin
      wr(2, 8'h42 | 8'(g));
      wr(0, 8'h44);
      #5000 tbSda = 1'b0;
      #5000 tbScl = 1'b0;
      for (int b = 0; b < 9; b++) busBit(b == 8, ack);
      repeat (200) @(negedge clk);
      chk("gcFlag", wireControlReg[7], 8'(g));
      chk("gcAck", ack, 8'(1 - g));
      if (g == 1) chk("gcCode", busStateCodeReg[7:3], ST_GEN_CALL);
      wr(0, 8'h94);
      #20000 tbSda = 1'b0;
      #2500 tbScl = 1'b1;
      #2500 tbSda = 1'b1;
      $display("general call case %0d done", g);
    end
    rst();
    print_verdict();
  end
endmodule
`default_nettype wire
